/* shared/tx_irq_pkg.sv */
/*
  Package for the transmit path interrupt block: register offsets, field
  positions, reset values and the event strobe carrier.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package tx_irq_pkg;
  localparam logic [11:0] flags_offset = 12'h0248;
  localparam logic [11:0] enables_offset = 12'h024c;
  localparam logic [31:0] flags_reset = 32'h0000_0000;
  localparam logic [31:0] enables_reset = 32'h0000_0000;
  // writable enable bits: 31:28 reserved
  localparam logic [31:0] enables_writable = 32'h0fff_ffff;
  // enables/flags routed to summary bit one (27:16), rest to summary bit zero
  localparam logic [31:0] route_one_mask = 32'h0fff_0000;
  localparam logic [31:0] route_zero_mask = 32'h0000_ffff;
  localparam int async_tx_pos = 27;
  localparam int ack_overrun_pos = 26;
  localparam int ack_arrived_pos = 25;
  localparam int iso_tx_pos = 24;
  localparam int num_buffers = 8;

  // per-buffer error strobes from the transmit data path, one bit per buffer
  typedef struct packed {
    logic [7:0] flush_done;
    logic [7:0] flush_on_error_enable;
    logic [7:0] continuity_error;
    logic [7:0] header_error;
  } buffer_events_t;

  // path-wide error strobes
  typedef struct packed {
    logic retry_exhausted;
    logic error_ack;
    logic illegal_tcode;
    logic ack_overrun;
    logic ack_arrived;
    logic iso_tx_error;
  } path_events_t;

  // flag bit positions for buffer n
  function automatic int flush_pos(input int n);
    return (n < 4) ? 23 - n : 15 - n;
  endfunction : flush_pos

  function automatic int continuity_pos(input int n);
    return (n < 4) ? 19 - n : 11 - n;
  endfunction : continuity_pos

  function automatic int header_pos(input int n);
    return (n < 4) ? 15 - n : 7 - n;
  endfunction : header_pos
endpackage : tx_irq_pkg

/* verilog/tx_path_error_interrupts.sv */
/*
  Transmit path error interrupt flags and enables with an APB slave.
  Assumes single-cycle strobes from the data path on the same clock,
  and an APB master that holds a request until pready.
*/
//
// Contract
// - flush flags buffers 1-3 at bits 22:20
// - flush flags buffers 4-7 at bits 11:8
// - flush flag only when flush-on-error enabled
// - continuity flags at 19:16 and 7:4
// - header flags at 15:12 and 3:0
// - enabled set flag drives summary bit
// - enable 27 gates async tx error
// - enables 26:24 gate ack and iso flags
// - enables 23:20 gate flush flags 0-3
// - enable bits 31:28 read zero, ignore writes
// - bits 15:0 feed summary bit zero
// - async error from retry, ack, tcode
`timescale 1ns/1ps
module tx_path_error_interrupts
  import tx_irq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data path strobes
  input wire buffer_events_t buffer_events,
  input wire path_events_t path_events,
  // summary outputs to the system interrupt register
  output logic summary_bit_one,
  output logic summary_bit_zero,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] tx_path_irq_flags;
  logic [31:0] tx_path_irq_enables;
  logic [31:0] set_vector;
  logic [7:0] flush_set;
  logic [7:0] continuity_set;
  logic [7:0] header_set;
  logic async_set;
  logic access;
  logic read_setup;
  logic flags_hit;
  logic enables_hit;
  logic flags_read;
  logic enables_write;
  logic mapped;

  // address decode shared by the bus strobes
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
    return addr == offset;
  endfunction : reg_hit

  assign access = psel && penable;
  assign flags_hit = reg_hit(paddr, flags_offset);
  assign enables_hit = reg_hit(paddr, enables_offset);
  assign mapped = flags_hit || enables_hit;
  assign read_setup = psel && !penable && !pwrite;
  assign flags_read = access && !pwrite && flags_hit;
  assign enables_write = access && pwrite && enables_hit;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  //////////////////////////////////////////////////////////////////////////////
  // per-buffer strobe qualification
  for (genvar n = 0; n < num_buffers; n++) begin : buffer_g
    // a flush only counts while that buffer flushes on error
    assign flush_set[n] = buffer_events.flush_done[n] && buffer_events.flush_on_error_enable[n];
    assign continuity_set[n] = buffer_events.continuity_error[n];
    assign header_set[n] = buffer_events.header_error[n];
  end : buffer_g

  assign async_set = path_events.retry_exhausted || path_events.error_ack ||
                     path_events.illegal_tcode;

  //////////////////////////////////////////////////////////////////////////////
  // event vector in flag layout
  always_comb begin
    set_vector = 32'h0000_0000;
    set_vector[async_tx_pos] = async_set;
    set_vector[ack_overrun_pos] = path_events.ack_overrun;
    set_vector[ack_arrived_pos] = path_events.ack_arrived;
    set_vector[iso_tx_pos] = path_events.iso_tx_error;
    for (int n = 0; n < num_buffers; n++) begin
      set_vector[flush_pos(n)] = flush_set[n];
      set_vector[continuity_pos(n)] = continuity_set[n];
      set_vector[header_pos(n)] = header_set[n];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags clear on read; a same-cycle event wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_path_irq_flags <= flags_reset;
    end else if (flags_read) begin
      // clear only what the read returned; events after the snapshot survive
      tx_path_irq_flags <= (tx_path_irq_flags & ~prdata) | set_vector;
    end else begin
      tx_path_irq_flags <= tx_path_irq_flags | set_vector;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_path_irq_enables <= enables_reset;
    end else if (enables_write) begin
      tx_path_irq_enables <= pwdata & enables_writable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        flags_offset: prdata <= tx_path_irq_flags;
        enables_offset: prdata <= tx_path_irq_enables;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // summary bits: 27:16 to bit one, 15:0 to bit zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      summary_bit_one <= 1'b0;
      summary_bit_zero <= 1'b0;
    end else begin
      summary_bit_one <= |(tx_path_irq_flags & tx_path_irq_enables & route_one_mask);
      summary_bit_zero <= |(tx_path_irq_flags & tx_path_irq_enables & route_zero_mask);
    end
  end

  assign irq = summary_bit_one || summary_bit_zero;

  //////////////////////////////////////////////////////////////////////////////
  // event capture
  flush_gated_a: assert property (@(posedge clock) disable iff (!rst_n)
    (buffer_events.flush_done[1] && !buffer_events.flush_on_error_enable[1] && !tx_path_irq_flags[22])
      |=> !tx_path_irq_flags[22])
    else $error("flush flag set without enable");

  flush_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    (buffer_events.flush_done[5] && buffer_events.flush_on_error_enable[5])
      |=> tx_path_irq_flags[10])
    else $error("flush flag 5 missed");

  flush_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    (buffer_events.flush_done[3] && buffer_events.flush_on_error_enable[3])
      |=> tx_path_irq_flags[20])
    else $error("flush flag 3 missed");

  continuity_pos_a: assert property (@(posedge clock) disable iff (!rst_n)
    buffer_events.continuity_error[4]
      |=> tx_path_irq_flags[7])
    else $error("continuity flag 4 missed");

  header_pos_a: assert property (@(posedge clock) disable iff (!rst_n)
    buffer_events.header_error[0]
      |=> tx_path_irq_flags[15])
    else $error("header flag 0 missed");

  async_err_a: assert property (@(posedge clock) disable iff (!rst_n)
    (path_events.retry_exhausted || path_events.error_ack || path_events.illegal_tcode)
      |=> tx_path_irq_flags[27])
    else $error("async tx error flag missed");

  ack_overrun_a: assert property (@(posedge clock) disable iff (!rst_n)
    path_events.ack_overrun
      |=> tx_path_irq_flags[26])
    else $error("ack overrun flag missed");

  ack_arrived_a: assert property (@(posedge clock) disable iff (!rst_n)
    path_events.ack_arrived
      |=> tx_path_irq_flags[25])
    else $error("ack arrived flag missed");

  iso_error_a: assert property (@(posedge clock) disable iff (!rst_n)
    path_events.iso_tx_error
      |=> tx_path_irq_flags[24])
    else $error("iso tx error flag missed");

  // every buffer lands on its own flag bits
  for (genvar n = 0; n < num_buffers; n++) begin : buffer_check_g
    flush_map_a: assert property (@(posedge clock) disable iff (!rst_n)
      flush_set[n]
        |=> tx_path_irq_flags[flush_pos(n)])
      else $error("flush flag missed");

    flush_block_a: assert property (@(posedge clock) disable iff (!rst_n)
      (buffer_events.flush_done[n] && !buffer_events.flush_on_error_enable[n] && !tx_path_irq_flags[flush_pos(n)])
        |=> !tx_path_irq_flags[flush_pos(n)])
      else $error("flush flag set without enable");

    continuity_map_a: assert property (@(posedge clock) disable iff (!rst_n)
      buffer_events.continuity_error[n]
        |=> tx_path_irq_flags[continuity_pos(n)])
      else $error("continuity flag missed");

    header_map_a: assert property (@(posedge clock) disable iff (!rst_n)
      buffer_events.header_error[n]
        |=> tx_path_irq_flags[header_pos(n)])
      else $error("header flag missed");
  end : buffer_check_g

  //////////////////////////////////////////////////////////////////////////////
  // flag register
  reserved_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1
      |-> tx_path_irq_flags[31:28] == 4'h0)
    else $error("reserved flag bits nonzero");

  read_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (flags_read && set_vector == 32'h0000_0000)
      |=> (tx_path_irq_flags & $past(prdata)) == 32'h0000_0000)
    else $error("flags not cleared by read");

  read_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    flags_read
      |=> (tx_path_irq_flags & $past(set_vector)) == $past(set_vector))
    else $error("event lost to read clear");

  flags_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!flags_read && set_vector == 32'h0000_0000)
      |=> $stable(tx_path_irq_flags))
    else $error("flags changed without cause");

  flags_snapshot_a: assert property (@(posedge clock) disable iff (!rst_n)
    (read_setup && flags_hit)
      |=> prdata == $past(tx_path_irq_flags))
    else $error("flag read data wrong");

  //////////////////////////////////////////////////////////////////////////////
  // enable register
  reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1
      |-> tx_path_irq_enables[31:28] == 4'h0)
    else $error("reserved enable bits nonzero");

  enables_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    enables_write
      |=> tx_path_irq_enables == ($past(pwdata) & enables_writable))
    else $error("enable write not taken");

  enables_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    !enables_write
      |=> $stable(tx_path_irq_enables))
    else $error("enables changed without write");

  reserved_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (read_setup && enables_hit)
      |=> prdata[31:28] == 4'h0)
    else $error("reserved enable bits read nonzero");

  //////////////////////////////////////////////////////////////////////////////
  // summary bits
  summary_one_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_path_irq_flags[27] && tx_path_irq_enables[27])
      |=> summary_bit_one)
    else $error("summary one not raised");

  summary_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((tx_path_irq_flags & tx_path_irq_enables) == 32'h0000_0000)
      |=> !summary_bit_zero && !summary_bit_one)
    else $error("summary raised with nothing enabled");

  summary_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|(tx_path_irq_flags[15:0] & tx_path_irq_enables[15:0]))
      |=> summary_bit_zero)
    else $error("summary zero not raised");

  flush_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|(tx_path_irq_flags[23:20] & tx_path_irq_enables[23:20]))
      |=> summary_bit_one)
    else $error("flush summary not raised");

  ack_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|(tx_path_irq_flags[26:24] & tx_path_irq_enables[26:24]))
      |=> summary_bit_one)
    else $error("ack summary not raised");

  continuity_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|(tx_path_irq_flags[19:16] & tx_path_irq_enables[19:16]))
      |=> summary_bit_one)
    else $error("continuity summary not raised");

  one_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((tx_path_irq_flags & tx_path_irq_enables & route_one_mask) == 32'h0000_0000)
      |=> !summary_bit_one)
    else $error("summary one raised by masked flag");

  zero_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((tx_path_irq_flags & tx_path_irq_enables & route_zero_mask) == 32'h0000_0000)
      |=> !summary_bit_zero)
    else $error("summary zero raised by masked flag");

endmodule : tx_path_error_interrupts

/* tb/test_tx_path_error_interrupts.sv */
/*
  Self-checking bench for the transmit path error interrupt block.
  Assumes the design answers APB with zero wait states and one-cycle strobes.
*/
`timescale 1ns/1ps
module test_tx_path_error_interrupts
  import tx_irq_pkg::*;
;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic summary_bit_one, summary_bit_zero, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, en;
  logic [7:0] fl, cfg, co, he;
  logic [5:0] pe;
  logic err;
  int error_cnt, n_tests, cyc;
  buffer_events_t buffer_events;
  path_events_t path_events;
  assign buffer_events = {fl, cfg, co, he};
  assign path_events = pe;
  tx_path_error_interrupts dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .buffer_events(buffer_events), .path_events(path_events),
    .summary_bit_one(summary_bit_one), .summary_bit_zero(summary_bit_zero), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // pulse strobes, check summaries, then read the flags twice
  task fire(input logic [7:0] f, c, h, input logic [5:0] p, input logic [31:0] exp);
    @(posedge clock);
    fl <= f; co <= c; he <= h; pe <= p;
    @(posedge clock);
    fl <= 8'h00; co <= 8'h00; he <= 8'h00; pe <= 6'h00;
    repeat (2) @(posedge clock);
    chk("summary one", {31'h0, |(exp & en & 32'h0fff_0000)}, {31'h0, summary_bit_one});
    chk("summary zero", {31'h0, |(exp & en & 32'h0000_ffff)}, {31'h0, summary_bit_zero});
    chk("irq", {31'h0, |(exp & en)}, {31'h0, irq});
    apb(1'b0, 12'h248, 32'h0000_0000);
    chk("flags", exp, rd);
    apb(1'b0, 12'h248, 32'h0000_0000);
    chk("flags cleared", 32'h0000_0000, rd);
  endtask : fire
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, fl, co, he, pe} = '0;
    cfg = 8'h00; en = 32'h0000_0000; error_cnt = 0; n_tests = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 12'h248, 32'h0000_0000);
    chk("flags reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h24c, 32'h0000_0000);
    chk("enables reset", 32'h0000_0000, rd);
    apb(1'b1, 12'h24c, 32'hffff_ffff);
    apb(1'b0, 12'h24c, 32'h0000_0000);
    chk("enables readback", 32'h0fff_ffff, rd);
    en = 32'h0fff_ffff;
    apb(1'b0, 12'h250, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      cfg <= 8'h00;
      fire(8'h01 << i, 8'h00, 8'h00, 6'h00, 32'h0000_0000);
      cfg <= 8'hff;
      fire(8'h01 << i, 8'h00, 8'h00, 6'h00, 32'h1 << ((i < 4) ? 23 - i : 15 - i));
      fire(8'h00, 8'h01 << i, 8'h00, 6'h00, 32'h1 << ((i < 4) ? 19 - i : 11 - i));
      fire(8'h00, 8'h00, 8'h01 << i, 6'h00, 32'h1 << ((i < 4) ? 15 - i : 7 - i));
    end
    for (int j = 0; j < 6; j++) begin
      fire(8'h00, 8'h00, 8'h00, 6'h01 << j, 32'h1 << ((j >= 3) ? 27 : 24 + j));
    end
    $display("test event map done");
    apb(1'b1, 12'h24c, 32'h0000_0000);
    en = 32'h0000_0000;
    fire(8'h00, 8'h80, 8'h01, 6'h20, 32'h0800_8010);
    apb(1'b1, 12'h248, 32'hffff_ffff);
    apb(1'b0, 12'h248, 32'h0000_0000);
    chk("flags write ignored", 32'h0000_0000, rd);
    // header strobe lands in the setup cycle of a flags read
    fork
      apb(1'b0, 12'h248, 32'h0000_0000);
      begin
        @(posedge clock);
        he <= 8'h01;
        @(posedge clock);
        he <= 8'h00;
      end
    join
    chk("read during event", 32'h0000_0000, rd);
    apb(1'b0, 12'h248, 32'h0000_0000);
    chk("event kept", 32'h0000_8000, rd);
    $display("test masking done");
    stop_test();
  end
endmodule : test_tx_path_error_interrupts
